/* common/charge_setpoint_pkg.sv */
/*
 Constants, types and timing for the charge setpoint limiter.
 Assumes a 40 MHz system clock and comparator inputs asynchronous to it.
*/
`default_nettype none
package charge_setpoint_pkg;
   //----------------------------------------
   // Register map
   //----------------------------------------
   localparam logic [3:0] ADDR_VOLT_REQ  = 4'h0; // Requested voltage, mV
   localparam logic [3:0] ADDR_CURR_REQ  = 4'h1; // Requested current, mA
   localparam logic [3:0] ADDR_OPTION    = 4'h2; // Option bits
   localparam logic [3:0] ADDR_STATUS    = 4'h3; // Status bits
   localparam logic [3:0] ADDR_VOLT_OUT  = 4'h4; // Programmed output voltage
   localparam logic [3:0] ADDR_CURR_OUT  = 4'h5; // Effective current setpoint
   localparam int OPT_LOW_CURRENT_PULSE_MODE_DIS_BIT       = 0;
   localparam int OPT_NEW_BATT_BIT       = 1;
   localparam int ST_VOLT_OR_BIT         = 0;
   localparam int ST_ADAPTER_BIT         = 1;
   localparam int ST_PWR_FAULT_BIT       = 2;
   localparam int ST_LOW_CURRENT_PULSE_MODE_BIT            = 3;
   localparam int ST_WAKE_BIT            = 4;
   localparam int ST_ADAPT_LIM_BIT       = 5;
   //----------------------------------------
   // Setpoint constants
   //----------------------------------------
   localparam logic [15:0] VREF_MV       = 16'h0450; // 1104mV
   localparam logic [15:0] VOUT_MIN_MV   = 16'h0B54; // 2900mV
   localparam logic [15:0] VSTEP_MASK    = 16'hFFF0; // 16mV steps
   localparam logic [15:0] WAKE_MA       = 16'h0050; // 80mA
   localparam logic [15:0] CURR_CEIL_MA [4] = '{16'h03FF, 16'h07FE, 16'h0BFC, 16'h0FFC};
   localparam logic [15:0] CURR_STEP_MASK [4] = '{16'hFFFF, 16'hFFFE, 16'hFFFC, 16'hFFFC};
   localparam logic [15:0] VOLT_CEIL_MV [5] = '{16'h1090, 16'h10D0, 16'h1150, 16'h11A0, 16'h1580};
   //----------------------------------------
   // Timing
   //----------------------------------------
   localparam int CLK_HZ          = 40_000_000;
   localparam int LOW_CURRENT_PULSE_MODE_BIT_MS     = 45;
   localparam int LOW_CURRENT_PULSE_MODE_BIT_CYC    = (CLK_HZ / 1000) * LOW_CURRENT_PULSE_MODE_BIT_MS;
   localparam int SEL_STABLE_CYC  = 16;
   localparam int PULSE_PERIOD    = 8; // Pulse train period, 1 high of 8
   //----------------------------------------
   // Types
   //----------------------------------------
   typedef struct packed {
      logic ok_130mv;  // Input above sense by 130mV
      logic ok_25mv;   // Input above sense by 25mV
      logic ok_neg25mv; // Input above sense minus 25mV
      logic adapt_hi;  // Adapter sense above threshold
      logic adapt_lo;  // Adapter sense below threshold minus hysteresis
      logic clim_100mv; // Adapter current sense above 100mV
   } comp_t;
   typedef struct packed {
      logic charge_en;
      logic fet_slow_off;
      logic fet_fast_off;
      logic adapter_detect;
      logic adapt_limit;
   } pins_t;
   typedef enum logic [1:0] {
      FET_OFF  = 2'b00,
      FET_ON   = 2'b01,
      FET_SLOW = 2'b10,
      FET_FAST = 2'b11
   } fet_state_t;
endpackage
`default_nettype wire

/* dv/charge_setpoint_limiter_assertions.sv */
/* Port checker for the charge setpoint limiter.
   Assumes comparator levels come from the front-end model. */
`default_nettype none
module charge_setpoint_limiter_checker
   import charge_setpoint_pkg::*;
(
   input wire logic        clk_sys,  // System clock
   input wire logic        rst_n,    // Reset, active low
   input wire logic        rd_stb,   // Read strobe
   input wire logic [15:0] rdata,    // Read data
   input wire comp_t       comp_raw, // Comparator levels
   input wire logic [15:0] volt_dac, // Voltage code
   input wire pins_t       pins      // Pin controls
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   //----------------------------------------
   // Port relations
   //----------------------------------------
   read_idle_a: assert property (!$past(rd_stb) |-> rdata == 16'h0000)
      else $error("read data not zero outside read");
   volt_cap_a: assert property (volt_dac <= 16'h1130)
      else $error("voltage code above top ceiling");
   charge_hold_a: assert property ((!comp_raw.ok_130mv && !pins.charge_en) [*8] |=> !pins.charge_en)
      else $error("charge enable rose without headroom");
   fast_off_a: assert property ((!comp_raw.ok_neg25mv) [*8] |-> pins.fet_fast_off && !pins.charge_en)
      else $error("reverse input not cut fast");
   adapter_set_a: assert property (comp_raw.adapt_hi [*8] |-> pins.adapter_detect)
      else $error("adapter detect not set");
   adapter_clear_a: assert property (comp_raw.adapt_lo [*8] |-> !pins.adapter_detect)
      else $error("adapter detect not cleared");
   adapter_hold_a: assert property ((!comp_raw.adapt_hi && !comp_raw.adapt_lo) [*8] |=> $stable(pins.adapter_detect))
      else $error("adapter detect chattered");
   limit_follow_a: assert property ($stable(comp_raw.clim_100mv) [*8] |-> pins.adapt_limit == comp_raw.clim_100mv)
      else $error("adapter limiting does not follow sense");
   // Main scenarios reached
   cover property (pins.fet_fast_off);
   cover property (pins.adapt_limit);
   cover property (volt_dac == 16'h1130);
endmodule
bind charge_setpoint_limiter charge_setpoint_limiter_checker u_charge_setpoint_limiter_checker (.clk_sys(clk_sys),
   .rst_n(rst_n), .rd_stb(rd_stb), .rdata(rdata), .comp_raw(comp_raw), .volt_dac(volt_dac), .pins(pins));
`default_nettype wire

/* dv/charge_setpoint_limiter_tb.sv */
/* Self-checking bench for the charge setpoint limiter.
   Assumes the comparator model and a 40 MHz clock. */
`default_nettype none
module charge_setpoint_limiter_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import charge_setpoint_pkg::*;
   //----------------------------------------
   // Signals, clock and instances
   //----------------------------------------
   logic        clk_sys = 1'b0;
   logic        rst_n = 1'b0;
   logic [3:0]  addr = 4'h0;
   logic [15:0] wdata = 16'h0000;
   logic        wr_stb = 1'b0;
   logic        rd_stb = 1'b0;
   logic [1:0]  cur_sel_raw = 2'h0;
   logic [2:0]  vol_sel_raw = 3'h0;
   logic        wake_req = 1'b0;
   logic [1:0]  adapt_lvl = 2'h2;
   logic        clim = 1'b0;
   int          headroom = 200;
   int          failures = 0;
   int          n_checks = 0;
   int          cyc = 0;
   int          n;
   logic [15:0] rdata;
   logic [15:0] volt_dac;
   logic [15:0] d;
   logic        curr_dac_bit;
   comp_t       comp_raw;
   pins_t       pins;
   logic [15:0] ci [5] = '{16'h03FF, 16'h07FE, 16'h0BFC, 16'h0FFC, 16'h0FFC};
   logic [15:0] vc [5] = '{16'h0C40, 16'h0C80, 16'h0D00, 16'h0D50, 16'h1130};
   logic [15:0] vr [5] = '{16'h0FA0, 16'h0FA7, 16'h03E8, 16'h1586, 16'h15B0};
   logic [15:0] ve [5] = '{16'h0B50, 16'h0B50, 16'h0000, 16'h1130, 16'h1130};
   logic        vo [5] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
   always #12.5 clk_sys = ~clk_sys;
   charge_setpoint_limiter #(.LOW_CURRENT_PULSE_MODE_CYC(8)) u_charge_setpoint_limiter (.clk_sys(clk_sys), .rst_n(rst_n),
      .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .cur_sel_raw(cur_sel_raw),
      .vol_sel_raw(vol_sel_raw), .comp_raw(comp_raw), .wake_req(wake_req), .volt_dac(volt_dac),
      .curr_dac_bit(curr_dac_bit), .pins(pins));
   comp_front_model u_comp_front_model (.clk_sys(clk_sys), .headroom(headroom), .adapt_lvl(adapt_lvl),
      .clim(clim), .comp_raw(comp_raw));
   //----------------------------------------
   // Bus, compare and closing tasks
   //----------------------------------------
   task automatic end_sim;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      n_checks++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH %0t word %h expected %h", $time, g, e);
      end
   endtask
   task automatic chb(input logic g, input logic e);
      n_checks++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH %0t bit %b expected %b", $time, g, e);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] v);
      @(posedge clk_sys);
      addr <= a;
      wdata <= v;
      wr_stb <= 1'b1;
      @(posedge clk_sys);
      wr_stb <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [15:0] v);
      @(posedge clk_sys);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge clk_sys);
      rd_stb <= 1'b0;
      @(negedge clk_sys);
      v = rdata;
   endtask
   task automatic settle;
      repeat (8) @(posedge clk_sys);
      @(negedge clk_sys);
   endtask
   // Count high bits of the current modulator
   task automatic cnt(input int c);
      n = 0;
      repeat (c) begin
         @(negedge clk_sys);
         n += int'(curr_dac_bit === 1'b1);
      end
   endtask
   task automatic rst(input logic [2:0] v, input logic [1:0] c);
      @(posedge clk_sys);
      rst_n <= 1'b0;
      vol_sel_raw <= v;
      cur_sel_raw <= c;
      repeat (6) @(posedge clk_sys);
      chk(volt_dac, 16'h0000);
      rst_n <= 1'b1;
      repeat (30) @(posedge clk_sys);
   endtask
   //----------------------------------------
   // Scenarios
   //----------------------------------------
   // Every select class, with selects moved after the latch
   task automatic sc_class;
      for (int k = 0; k < 5; k++) begin
         rst(3'(k), (k > 3) ? 2'h3 : 2'(k));
         vol_sel_raw <= 3'h4;
         cur_sel_raw <= 2'h3;
         repeat (30) @(posedge clk_sys);
         rd(ADDR_STATUS, d);
         chb(d[ST_WAKE_BIT], 1'b1);
         wr(ADDR_VOLT_REQ, 16'h1770);
         wr(ADDR_CURR_REQ, 16'h1388);
         rd(ADDR_CURR_OUT, d);
         chk(d, ci[k]);
         rd(ADDR_STATUS, d);
         chk(volt_dac, vc[k]);
         chb(d[ST_VOLT_OR_BIT], 1'b1);
         chb(d[ST_WAKE_BIT], 1'b0);
      end
      rd(4'hF, d);
      chk(d, 16'h0000);
   endtask
   // Offset, zero floor, step and over-range boundary
   task automatic sc_volt;
      for (int i = 0; i < 5; i++) begin
         wr(ADDR_VOLT_REQ, vr[i]);
         rd(ADDR_STATUS, d);
         chk(volt_dac, ve[i]);
         chb(d[ST_VOLT_OR_BIT], vo[i]);
      end
   endtask
   // Density, full scale, pulse mode, its disable, wake-up
   task automatic sc_cur;
      wr(ADDR_CURR_REQ, 16'h0BB9);
      rd(ADDR_CURR_OUT, d);
      chk(d, 16'h0BB8);
      cnt(1023);
      chb(n >= 748 && n <= 752, 1'b1);
      wr(ADDR_CURR_REQ, 16'h1388);
      settle();
      cnt(64);
      chb(n == 64, 1'b1);
      wr(ADDR_CURR_REQ, 16'h0100);
      rd(ADDR_STATUS, d);
      chb(d[ST_LOW_CURRENT_PULSE_MODE_BIT], 1'b0);
      wr(ADDR_CURR_REQ, 16'h00C8);
      rd(ADDR_STATUS, d);
      chb(d[ST_LOW_CURRENT_PULSE_MODE_BIT], 1'b1);
      cnt(800);
      chb(n >= 37 && n <= 41, 1'b1);
      wr(ADDR_OPTION, 16'h0001);
      rd(ADDR_STATUS, d);
      chb(d[ST_LOW_CURRENT_PULSE_MODE_BIT], 1'b0);
      cnt(1023);
      chb(n >= 48 && n <= 52, 1'b1);
      wr(ADDR_OPTION, 16'h0002);
      rd(ADDR_CURR_OUT, d);
      chk(d, 16'h0050);
      wr(ADDR_VOLT_REQ, 16'h0FA0);
      rd(ADDR_STATUS, d);
      chb(d[ST_WAKE_BIT], 1'b1);
      wr(ADDR_CURR_REQ, 16'h00C8);
      rd(ADDR_STATUS, d);
      chb(d[ST_WAKE_BIT], 1'b0);
      wake_req <= 1'b1;
      settle();
      rd(ADDR_CURR_OUT, d);
      chk(d, 16'h0050);
      wake_req <= 1'b0;
   endtask
   // Input switch headroom steps
   task automatic sc_power;
      settle();
      chb(pins.charge_en, 1'b1);
      headroom <= 0;
      settle();
      chb(pins.fet_slow_off, 1'b1);
      headroom <= -50;
      settle();
      chb(pins.fet_fast_off, 1'b1);
      chb(pins.charge_en, 1'b0);
      headroom <= 100;
      settle();
      rd(ADDR_STATUS, d);
      chb(pins.charge_en, 1'b0);
      chb(d[ST_PWR_FAULT_BIT], 1'b1);
      headroom <= 200;
      settle();
      chb(pins.charge_en, 1'b1);
   endtask
   // Adapter hysteresis and adapter limiting
   task automatic sc_adapt;
      logic e [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
      for (int i = 0; i < 4; i++) begin
         adapt_lvl <= (i == 0) ? 2'h2 : (i == 2) ? 2'h0 : 2'h1;
         settle();
         rd(ADDR_STATUS, d);
         chb(pins.adapter_detect, e[i]);
         chb(d[ST_ADAPTER_BIT], e[i]);
      end
      clim <= 1'b1;
      settle();
      rd(ADDR_STATUS, d);
      chb(pins.adapt_limit, 1'b1);
      chb(d[ST_ADAPT_LIM_BIT], 1'b1);
      clim <= 1'b0;
      adapt_lvl <= 2'h2;
      settle();
   endtask
   // Cycle ceiling against a hang
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         failures++;
         end_sim();
      end
   end
   initial begin
      sc_class();
      sc_volt();
      sc_cur();
      sc_power();
      sc_adapt();
      end_sim();
   end
endmodule
`default_nettype wire

/* dv/comp_front_model.sv */
/* Analog comparator front end: turns headroom and adapter levels into
   comparator bits. Assumes the bench sets the analog values. */
`default_nettype none
module comp_front_model
   import charge_setpoint_pkg::*;
(
   input wire logic       clk_sys,       // System clock
   input var int          headroom,      // Input minus sense, mV
   input wire logic [1:0] adapt_lvl,     // 0 low, 1 in hysteresis, 2 high
   input wire logic       clim,          // Adapter sense above limit
   output var comp_t      comp_raw = '0  // Comparator levels
);
   timeunit 1ns;
   timeprecision 100ps;
   // Thresholds change just after the clock edge
   always @(posedge clk_sys) begin
      comp_raw.ok_130mv <= headroom >= 130;
      comp_raw.ok_25mv <= headroom >= 25;
      comp_raw.ok_neg25mv <= headroom >= -25;
      comp_raw.adapt_hi <= adapt_lvl == 2'h2;
      comp_raw.adapt_lo <= adapt_lvl == 2'h0;
      comp_raw.clim_100mv <= clim;
   end
endmodule
`default_nettype wire

/* verilog/charge_setpoint_limiter.sv */
/*
 Charge setpoint limiter: clamps voltage and current requests to resistor
 selected ceilings, drives the current delta-sigma bit, and keeps input and
 adapter status. Assumes comparator and select inputs are asynchronous.
*/
// Decided for this implementation: the placing of the registers and strobed register access.
`default_nettype none
module charge_setpoint_limiter
   import charge_setpoint_pkg::*;
#(
   parameter int LOW_CURRENT_PULSE_MODE_CYC = LOW_CURRENT_PULSE_MODE_BIT_CYC
) (
   input  wire logic        clk_sys,   // 40 MHz clock
   input  wire logic        rst_n,     // Async reset, active low
   input  wire logic [3:0]  addr,      // Register address
   input  wire logic [15:0] wdata,     // Write data
   input  wire logic        wr_stb,    // Write strobe
   input  wire logic        rd_stb,    // Read strobe
   output logic      [15:0] rdata,     // Read data, cycle after strobe
   input  wire logic [1:0]  cur_sel_raw, // Current select comparator code
   input  wire logic [2:0]  vol_sel_raw, // Voltage select comparator code
   input  wire charge_setpoint_pkg::comp_t comp_raw, // Analog comparator results
   input  wire logic        wake_req,  // Wake-up request to current DAC
   output logic [15:0]      volt_dac,  // Voltage DAC code, mV above ref
   output logic             curr_dac_bit, // Current delta-sigma bit
   output charge_setpoint_pkg::pins_t pins // Pin and switch controls
);
   import charge_setpoint_pkg::*;

   //----------------------------------------
   // Reset and input synchronisers
   //----------------------------------------
   logic [1:0] rst_sync_r;
   logic       rst_l;
   logic [4:0] sel_s1_r, sel_s2_r;
   comp_t      comp_s1_r, comp_s2_r;

   // Release reset through two flip-flops
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) rst_sync_r <= 2'b00;
      else rst_sync_r <= {rst_sync_r[0], 1'b1};
   end
   assign rst_l = rst_sync_r[1];

   // Two-stage synchronisers for all analog inputs
   always_ff @(posedge clk_sys or negedge rst_l) begin
      if (!rst_l) begin
         sel_s1_r  <= 5'h00;
         sel_s2_r  <= 5'h00;
         comp_s1_r <= '0;
         comp_s2_r <= '0;
      end else begin
         sel_s1_r  <= {vol_sel_raw, cur_sel_raw};
         sel_s2_r  <= sel_s1_r;
         comp_s1_r <= comp_raw;
         comp_s2_r <= comp_s1_r;
      end
   end

   //----------------------------------------
   // Select class latch
   //----------------------------------------
   logic [4:0] sel_prev_r;
   logic [4:0] stable_cnt_r;
   logic       sel_valid_r;
   logic [1:0] cur_cls_r;
   logic [2:0] vol_cls_r;
   logic       sel_same;
   logic [2:0] vol_cls_in;

   assign sel_same   = (sel_s2_r == sel_prev_r);
   assign vol_cls_in = (sel_s2_r[4:2] > 3'h4) ? 3'h4 : sel_s2_r[4:2];

   // Latch classes once after they hold steady; later changes are ignored
   always_ff @(posedge clk_sys or negedge rst_l) begin
      if (!rst_l) begin
         sel_prev_r   <= 5'h00;
         stable_cnt_r <= 5'h00;
         sel_valid_r  <= 1'b0;
         cur_cls_r    <= 2'h0;
         vol_cls_r    <= 3'h0;
      end else begin
         sel_prev_r <= sel_s2_r;
         if (!sel_same) stable_cnt_r <= 5'h00;
         else if (stable_cnt_r != 5'(SEL_STABLE_CYC)) stable_cnt_r <= stable_cnt_r + 5'h01;
         if (!sel_valid_r && sel_same && stable_cnt_r == 5'(SEL_STABLE_CYC)) begin
            sel_valid_r <= 1'b1;
            cur_cls_r   <= sel_s2_r[1:0];
            vol_cls_r   <= vol_cls_in;
         end
      end
   end

   //----------------------------------------
   // Request registers
   //----------------------------------------
   logic [15:0] volt_req_r, curr_req_r;
   logic        low_current_pulse_mode_dis_r, new_batt_r;
   logic        got_volt_r, got_curr_r;
   logic        wr_volt, wr_curr, wr_opt;

   assign wr_volt = wr_stb && addr == ADDR_VOLT_REQ;
   assign wr_curr = wr_stb && addr == ADDR_CURR_REQ;
   assign wr_opt  = wr_stb && addr == ADDR_OPTION;

   // Software writes; setting the new-battery bit forgets both commands
   always_ff @(posedge clk_sys or negedge rst_l) begin
      if (!rst_l) begin
         volt_req_r <= 16'h0000;
         curr_req_r <= 16'h0000;
         low_current_pulse_mode_dis_r <= 1'b0;
         new_batt_r <= 1'b0;
         got_volt_r <= 1'b0;
         got_curr_r <= 1'b0;
      end else begin
         if (wr_volt) volt_req_r <= wdata;
         if (wr_curr) curr_req_r <= wdata;
         if (wr_opt) begin
            low_current_pulse_mode_dis_r <= wdata[OPT_LOW_CURRENT_PULSE_MODE_DIS_BIT];
            new_batt_r <= wdata[OPT_NEW_BATT_BIT];
         end else begin
            new_batt_r <= 1'b0;
         end
         // Fresh write wins over new-battery clear
         got_volt_r <= wr_volt || (got_volt_r && !new_batt_r);
         got_curr_r <= wr_curr || (got_curr_r && !new_batt_r);
      end
   end

   //----------------------------------------
   // Voltage path
   //----------------------------------------
   logic [15:0] vceil, vreq_q, volt_nxt;
   logic        volt_or_nxt;

   assign vceil       = VOLT_CEIL_MV[vol_cls_r];
   assign vreq_q      = volt_req_r & VSTEP_MASK;
   assign volt_or_nxt = vreq_q > vceil;
   assign volt_nxt    = (vreq_q < VREF_MV) ? 16'h0000 :
                        volt_or_nxt ? 16'(vceil - VREF_MV) :
                        16'(vreq_q - VREF_MV);

   //----------------------------------------
   // Current setpoint
   //----------------------------------------
   logic [15:0] cceil, cset, creq_q;
   logic        wake_act, low_current_pulse_mode_nxt;

   assign wake_act = wake_req || !(got_volt_r && got_curr_r);
   assign cceil    = CURR_CEIL_MA[cur_cls_r];
   assign creq_q   = curr_req_r & CURR_STEP_MASK[cur_cls_r];
   assign cset     = wake_act ? WAKE_MA :
                     (creq_q >= cceil) ? cceil : creq_q;
   assign low_current_pulse_mode_nxt = !low_current_pulse_mode_dis_r && (cset < (cceil >> 4));

   //----------------------------------------
   // Delta-sigma modulator and pulse train
   //----------------------------------------
   logic [16:0] acc_r;
   logic [16:0] acc_sum;
   logic [15:0] ds_in;
   logic [31:0] slow_cnt_r;
   logic [2:0]  pulse_cnt_r;
   logic        ds_bit_r, low_current_pulse_mode_r, step;

   // Pulse mode steps every 45ms, otherwise every clock
   assign step    = !low_current_pulse_mode_r || slow_cnt_r == 32'(LOW_CURRENT_PULSE_MODE_CYC - 1);
   // Pulses carry an eighth of full scale, so pulse mode runs eight times the
   // density to keep the average at the request; cset is below cceil/16 there
   assign ds_in   = low_current_pulse_mode_r ? {cset[12:0], 3'h0} : cset;
   assign acc_sum = acc_r + {1'b0, ds_in};

   // First-order modulator: density cset/cceil
   always_ff @(posedge clk_sys or negedge rst_l) begin
      if (!rst_l) begin
         acc_r       <= 17'h00000;
         ds_bit_r    <= 1'b0;
         slow_cnt_r  <= 32'h00000000;
         pulse_cnt_r <= 3'h0;
         low_current_pulse_mode_r      <= 1'b0;
      end else begin
         low_current_pulse_mode_r      <= low_current_pulse_mode_nxt;
         pulse_cnt_r <= pulse_cnt_r + 3'h1;
         slow_cnt_r  <= step ? 32'h00000000 : slow_cnt_r + 32'h00000001;
         if (step) begin
            if (acc_sum >= {1'b0, cceil}) begin
               acc_r    <= 17'(acc_sum - {1'b0, cceil});
               ds_bit_r <= 1'b1;
            end else begin
               acc_r    <= acc_sum;
               ds_bit_r <= 1'b0;
            end
         end
      end
   end

   // Pulse mode gates a 1-of-8 train with the modulator bit
   logic dac_bit_nxt;
   assign dac_bit_nxt = low_current_pulse_mode_r ? (ds_bit_r && pulse_cnt_r == 3'(PULSE_PERIOD - 1))
                               : ds_bit_r;

   //----------------------------------------
   // Input switch and adapter status
   //----------------------------------------
   fet_state_t fet_r, fet_nxt;
   logic       adapter_r, pwr_fault_r;

   // Enable at 130mV, slow off below 25mV, fast off below -25mV
   always_comb begin
      fet_nxt = fet_r;
      case (fet_r)
         FET_OFF:  if (comp_s2_r.ok_130mv) fet_nxt = FET_ON;
         FET_ON:   if (!comp_s2_r.ok_neg25mv) fet_nxt = FET_FAST;
                   else if (!comp_s2_r.ok_25mv) fet_nxt = FET_SLOW;
         FET_SLOW: if (!comp_s2_r.ok_neg25mv) fet_nxt = FET_FAST;
                   else if (comp_s2_r.ok_130mv) fet_nxt = FET_ON;
         FET_FAST: if (comp_s2_r.ok_130mv) fet_nxt = FET_ON;
         default:  fet_nxt = FET_OFF;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_l) begin
      if (!rst_l) begin
         fet_r       <= FET_OFF;
         adapter_r   <= 1'b0;
         pwr_fault_r <= 1'b1;
      end else begin
         fet_r       <= fet_nxt;
         pwr_fault_r <= (fet_nxt != FET_ON);
         if (comp_s2_r.adapt_hi) adapter_r <= 1'b1;
         else if (comp_s2_r.adapt_lo) adapter_r <= 1'b0;
      end
   end

   //----------------------------------------
   // Outputs and status
   //----------------------------------------
   logic volt_or_r;

   always_ff @(posedge clk_sys or negedge rst_l) begin
      if (!rst_l) begin
         volt_dac     <= 16'h0000;
         volt_or_r    <= 1'b0;
         curr_dac_bit <= 1'b0;
         pins         <= '0;
      end else begin
         volt_dac     <= volt_nxt;
         volt_or_r    <= volt_or_nxt;
         curr_dac_bit <= dac_bit_nxt;
         pins.charge_en      <= (fet_nxt == FET_ON) && sel_valid_r;
         pins.fet_slow_off   <= (fet_nxt == FET_SLOW);
         pins.fet_fast_off   <= (fet_nxt == FET_FAST);
         pins.adapter_detect <= adapter_r;
         pins.adapt_limit    <= comp_s2_r.clim_100mv;
      end
   end

   // Read mux, data valid the cycle after the strobe
   logic [15:0] status_w, rd_nxt;
   assign status_w = 16'({pins.adapt_limit, wake_act, low_current_pulse_mode_r, pwr_fault_r, adapter_r, volt_or_r});
   assign rd_nxt = !rd_stb ? 16'h0000 :
                   (addr == ADDR_VOLT_REQ) ? volt_req_r :
                   (addr == ADDR_CURR_REQ) ? curr_req_r :
                   (addr == ADDR_OPTION)   ? {15'h0000, low_current_pulse_mode_dis_r} :
                   (addr == ADDR_STATUS)   ? status_w :
                   (addr == ADDR_VOLT_OUT) ? volt_dac :
                   (addr == ADDR_CURR_OUT) ? cset : 16'h0000;

   always_ff @(posedge clk_sys or negedge rst_l) begin
      if (!rst_l) rdata <= 16'h0000;
      else rdata <= rd_nxt;
   end

endmodule
`default_nettype wire
